// >>> rtl/adc_sequencer_control.sv
// converter sequencer control behind the setup register
// Behaviour
// - each write to the setup register decodes the operation code in bits 10 to 8.
// - the argument in bits 7 to 5 is read according to the operation code of that write.
// - operation 000 sets the sequence length to the argument plus one slot.
// - operation 001 stores the input selection of that same write into the slot named by the argument.
// - operation 010 enables key sequencing for argument 001 and disables it otherwise.
// - operation 011 enables automatic sequencing for argument 001 and disables it otherwise.
// - operation 100 starts one conversion of the selected input and stops auto sequencing.
// - operation 101 arms single conversions triggered by the key code outside key sequencing.
// - bit 21 reads back the inverse of the fault pin level.
// - bits 20 to 16 read back a fixed register address that writers leave alone.
// - the register sits at location 0x11 and resets to 0x110000.
// - bits 4 to 0 select the converter input and unlisted codes give a zero result.
module adc_sequencer_control
   import adc_seq_pkg::*;
#(
   parameter int SEL_W    = SEL_WIDTH,
   parameter int RESULT_W = RESULT_WIDTH
) (
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   input  wire logic                   regWrite,
   input  wire logic                   regRead,
   input  wire logic [4:0]             regAddr,
   input  wire logic [SETUP_WIDTH-1:0] regWriteData,
   output logic      [SETUP_WIDTH-1:0] regReadData,
   input  wire logic                   keyStrobe,
   input  wire logic [KEY_WIDTH-1:0]   keyCode,
   input  wire logic                   faultPin,
   input  wire logic                   convDone,
   input  wire logic [RESULT_W-1:0]    convResult,
   output logic                        convStart,
   output logic      [SEL_W-1:0]       convSelect,
   output logic                        convBusy,
   output logic      [RESULT_W-1:0]    resultData,
   output logic      [SEL_W-1:0]       resultSelect,
   output logic                        resultValid,
   output logic                        autoSequencing,
   output logic                        keySequencing,
   output logic                        keyArmed
);

   // ---- stored register fields
   setup_reg_t       setup;
   setup_reg_t       next_setup;
   setup_reg_t       writeFields;
   logic             setupWrite;

   // ---- mode and length state
   logic [2:0]       lastSlot;
   logic [2:0]       next_lastSlot;
   logic             next_autoSequencing;
   logic             next_keySequencing;
   logic             next_keyArmed;
   logic             slotWrite;
   logic             pointerRestart;
   logic             singleCommand;

   // ---- pending conversion requests
   logic             keyHit;
   logic             pendSingle;
   logic             next_pendSingle;
   logic [SEL_W-1:0] pendSel;
   logic [SEL_W-1:0] next_pendSel;
   logic             pendSeq;
   logic             next_pendSeq;

   // ---- converter handshake
   conv_state_t        state;
   conv_state_t        next_state;
   logic               next_convStart;
   logic [SEL_W-1:0]   next_convSelect;
   logic               next_convBusy;
   logic [RESULT_W-1:0] next_resultData;
   logic [SEL_W-1:0]   next_resultSelect;
   logic               next_resultValid;
   logic               launchSingle;
   logic               launchSeq;
   logic               seqAdvance;
   logic [2:0]         slotPointer;
   logic [SEL_W-1:0]   slotSel;

   // ---- read port
   logic [SETUP_WIDTH-1:0] next_regReadData;
   setup_reg_t             readImage;

   assign setupWrite  = regWrite && (regAddr == SETUP_ADDR);
   assign writeFields = setup_reg_t'(regWriteData);
   assign keyHit      = keyStrobe && (keyCode == CONV_KEY);

   sequence_slot_table #(
      .SLOTS   (SLOT_COUNT),
      .SEL_W   (SEL_W),
      .INDEX_W (SLOT_BITS)
   ) u_slots (
      .clock       (clock),
      .rst_b       (rst_b),
      .slotWrite   (slotWrite),
      .slotIndex   (writeFields.arg),
      .slotSel     (writeFields.sel),
      .advance     (seqAdvance),
      .restart     (pointerRestart),
      .lastSlot    (lastSlot),
      .slotPointer (slotPointer),
      .currentSel  (slotSel)
   );

   // register field storage
   always_comb begin
      next_setup = setup;
      if (setupWrite) begin
         // address and fault bits are never written
         next_setup.spare = writeFields.spare;
         next_setup.cmd   = writeFields.cmd;
         next_setup.arg   = writeFields.arg;
         next_setup.sel   = writeFields.sel;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         setup <= setup_reg_t'(SETUP_RESET);
      end else begin
         setup <= next_setup;
      end
   end

   // command decode; the argument meaning follows the code of the same write
   always_comb begin
      next_lastSlot       = lastSlot;
      next_autoSequencing = autoSequencing;
      next_keySequencing  = keySequencing;
      next_keyArmed       = keyArmed;
      slotWrite           = 1'b0;
      pointerRestart      = 1'b0;
      singleCommand       = 1'b0;
      if (setupWrite) begin
         unique case (writeFields.cmd)
            CMD_DEPTH: begin
               next_lastSlot  = writeFields.arg;
               pointerRestart = 1'b1;
            end
            CMD_SLOT: begin
               slotWrite = 1'b1;
            end
            CMD_KEY_SEQ: begin
               // key sequencing on only for 001
               next_keySequencing = (writeFields.arg == ARG_ENABLE);
               pointerRestart     = !keySequencing && next_keySequencing;
            end
            CMD_AUTO_SEQ: begin
               // auto sequencing on only for 001
               next_autoSequencing = (writeFields.arg == ARG_ENABLE);
               pointerRestart      = !autoSequencing && next_autoSequencing;
            end
            CMD_SINGLE: begin
               next_autoSequencing = 1'b0;
               singleCommand       = 1'b1;
            end
            CMD_KEY_ARM: begin
               next_keyArmed = 1'b1;
            end
            CMD_RSVD6, CMD_RSVD7: begin
               // reserved codes leave every mode untouched
               next_keyArmed = keyArmed;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         lastSlot       <= SLOT_FIRST;
         autoSequencing <= 1'b0;
         keySequencing  <= 1'b0;
         keyArmed       <= 1'b0;
      end else begin
         lastSlot       <= next_lastSlot;
         autoSequencing <= next_autoSequencing;
         keySequencing  <= next_keySequencing;
         keyArmed       <= next_keyArmed;
      end
   end

   // pending requests; a new request in the cycle it is taken wins over the clear
   always_comb begin
      next_pendSingle = pendSingle;
      next_pendSel    = pendSel;
      next_pendSeq    = pendSeq;
      if (launchSingle) begin
         next_pendSingle = 1'b0;
      end
      if (launchSeq) begin
         next_pendSeq = 1'b0;
      end
      // immediate conversion of the selection just written
      if (singleCommand) begin
         next_pendSingle = 1'b1;
         next_pendSel    = writeFields.sel;
      end else if (keyHit && !keySequencing && keyArmed) begin
         // key conversion of the current selection
         next_pendSingle = 1'b1;
         next_pendSel    = setup.sel;
      end
      if (keyHit && keySequencing) begin
         next_pendSeq = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         pendSingle <= 1'b0;
         pendSel    <= '0;
         pendSeq    <= 1'b0;
      end else begin
         pendSingle <= next_pendSingle;
         pendSel    <= next_pendSel;
         pendSeq    <= next_pendSeq;
      end
   end

   // single requests go first so a sequence cannot starve a software request
   assign launchSingle = (state == CONV_IDLE) && pendSingle;
   assign launchSeq    = (state == CONV_IDLE) && !pendSingle && pendSeq;
   // sequenced launches step the slot pointer
   assign seqAdvance   = (state == CONV_IDLE) && !pendSingle
                         && (pendSeq || autoSequencing);

   // converter handshake
   always_comb begin
      next_state        = state;
      next_convStart    = 1'b0;
      next_convSelect   = convSelect;
      next_convBusy     = convBusy;
      next_resultData   = resultData;
      next_resultSelect = resultSelect;
      next_resultValid  = 1'b0;
      unique case (state)
         CONV_IDLE: begin
            if (launchSingle) begin
               next_convStart  = 1'b1;
               next_convSelect = pendSel;
               next_convBusy   = 1'b1;
               next_state      = CONV_WAIT;
            end else if (seqAdvance) begin
               // convert the slot under the pointer
               next_convStart  = 1'b1;
               next_convSelect = slotSel;
               next_convBusy   = 1'b1;
               next_state      = CONV_WAIT;
            end
         end
         CONV_WAIT: begin
            if (convDone) begin
               if (SEL_LISTED[convSelect]) begin
                  next_resultData = convResult;
               end else begin
                  next_resultData = RESULT_ZERO;
               end
               next_resultSelect = convSelect;
               next_resultValid  = 1'b1;
               next_convBusy     = 1'b0;
               next_state        = CONV_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state        <= CONV_IDLE;
         convStart    <= 1'b0;
         convSelect   <= '0;
         convBusy     <= 1'b0;
         resultData   <= RESULT_ZERO;
         resultSelect <= '0;
         resultValid  <= 1'b0;
      end else begin
         state        <= next_state;
         convStart    <= next_convStart;
         convSelect   <= next_convSelect;
         convBusy     <= next_convBusy;
         resultData   <= next_resultData;
         resultSelect <= next_resultSelect;
         resultValid  <= next_resultValid;
      end
   end

   // read port; other addresses belong to other blocks and read as zero here
   always_comb begin
      readImage          = setup;
      readImage.faultInv = !faultPin;
      readImage.regAddress = SETUP_ADDR;
      next_regReadData   = regReadData;
      if (regRead) begin
         if (regAddr == SETUP_ADDR) begin
            next_regReadData = readImage;
         end else begin
            next_regReadData = '0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         regReadData <= '0;
      end else begin
         regReadData <= next_regReadData;
      end
   end

endmodule : adc_sequencer_control

// >>> rtl/adc_seq_pkg.sv
// shared constants, field layout and types for the converter sequencer control
package adc_seq_pkg;

   localparam int          SETUP_WIDTH  = 22;
   localparam int          SEL_WIDTH    = 5;
   localparam int          SLOT_COUNT   = 8;
   localparam int          SLOT_BITS    = 3;
   localparam int          RESULT_WIDTH = 12;
   localparam int          KEY_WIDTH    = 16;

   // location of the setup register on the serial register port
   localparam logic [4:0]  SETUP_ADDR   = 5'h11;
   localparam logic [21:0] SETUP_RESET  = 22'h110000;

   // argument value that switches a sequencing mode on
   localparam logic [2:0]  ARG_ENABLE   = 3'h1;
   // key code that triggers conversions
   localparam logic [15:0] CONV_KEY     = 16'h1adc;
   // one bit per selection code that names a node; unlisted codes convert to zero
   localparam logic [31:0] SEL_LISTED   = 32'hffff707f;
   localparam logic [11:0] RESULT_ZERO  = 12'h000;
   localparam logic [2:0]  SLOT_FIRST   = 3'h0;
   localparam logic [2:0]  SLOT_STEP    = 3'h1;

   typedef enum logic [2:0] {
      CMD_DEPTH    = 3'b000,
      CMD_SLOT     = 3'b001,
      CMD_KEY_SEQ  = 3'b010,
      CMD_AUTO_SEQ = 3'b011,
      CMD_SINGLE   = 3'b100,
      CMD_KEY_ARM  = 3'b101,
      CMD_RSVD6    = 3'b110,
      CMD_RSVD7    = 3'b111
   } seq_cmd_t;

   // bit layout of the setup register, msb first
   typedef struct packed {
      logic                 faultInv;
      logic [4:0]           regAddress;
      logic [4:0]           spare;
      seq_cmd_t             cmd;
      logic [2:0]           arg;
      logic [SEL_WIDTH-1:0] sel;
   } setup_reg_t;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_WAIT = 2'b01
   } conv_state_t;

endpackage : adc_seq_pkg

// >>> rtl/sequence_slot_table.sv
// sequence slot store with the wrapping slot pointer
module sequence_slot_table
   import adc_seq_pkg::*;
#(
   parameter int SLOTS   = SLOT_COUNT,
   parameter int SEL_W   = SEL_WIDTH,
   parameter int INDEX_W = SLOT_BITS
) (
   input  wire logic               clock,
   input  wire logic               rst_b,
   input  wire logic               slotWrite,
   input  wire logic [INDEX_W-1:0] slotIndex,
   input  wire logic [SEL_W-1:0]   slotSel,
   input  wire logic               advance,
   input  wire logic               restart,
   input  wire logic [INDEX_W-1:0] lastSlot,
   output logic      [INDEX_W-1:0] slotPointer,
   output logic      [SEL_W-1:0]   currentSel
);

   logic [SEL_W-1:0]   slots      [SLOTS];
   logic [SEL_W-1:0]   next_slots [SLOTS];
   logic [INDEX_W-1:0] next_slotPointer;

   genvar i;
   generate
      for (i = 0; i < SLOTS; i++) begin : g_slot
         always_comb begin
            next_slots[i] = slots[i];
            if (slotWrite && slotIndex == INDEX_W'(i)) begin
               next_slots[i] = slotSel;
            end
         end

         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               slots[i] <= '0;
            end else begin
               slots[i] <= next_slots[i];
            end
         end
      end
   endgenerate

   always_comb begin
      next_slotPointer = slotPointer;
      if (restart) begin
         next_slotPointer = SLOT_FIRST;
      end else if (advance) begin
         if (slotPointer >= lastSlot) begin
            next_slotPointer = SLOT_FIRST;
         end else begin
            next_slotPointer = slotPointer + SLOT_STEP;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         slotPointer <= SLOT_FIRST;
      end else begin
         slotPointer <= next_slotPointer;
      end
   end

   assign currentSel = slots[slotPointer];

endmodule : sequence_slot_table

// >>> verification/adc_sequencer_control_props.sv
// assertion checker on the sequencer control ports
module adc_seq_checker
   import adc_seq_pkg::*;
#(
   parameter int SEL_W    = SEL_WIDTH,
   parameter int RESULT_W = RESULT_WIDTH
) (
   input wire logic                   clock,
   input wire logic                   rst_b,
   input wire logic                   regWrite,
   input wire logic                   regRead,
   input wire logic [4:0]             regAddr,
   input wire logic [SETUP_WIDTH-1:0] regWriteData,
   input wire logic [SETUP_WIDTH-1:0] regReadData,
   input wire logic                   keyStrobe,
   input wire logic [KEY_WIDTH-1:0]   keyCode,
   input wire logic                   faultPin,
   input wire logic                   convDone,
   input wire logic [RESULT_W-1:0]    convResult,
   input wire logic                   convStart,
   input wire logic [SEL_W-1:0]       convSelect,
   input wire logic                   convBusy,
   input wire logic [RESULT_W-1:0]    resultData,
   input wire logic [SEL_W-1:0]       resultSelect,
   input wire logic                   resultValid,
   input wire logic                   autoSequencing,
   input wire logic                   keySequencing,
   input wire logic                   keyArmed
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       wr;
   logic       idle;
   logic [2:0] cmd;
   logic [2:0] arg;
   logic [4:0] sel;
   assign wr  = regWrite && (regAddr == SETUP_ADDR);
   assign cmd = regWriteData[10:8];
   assign arg = regWriteData[7:5];
   assign sel = regWriteData[4:0];
   // fixed start latency only holds when nothing else can claim the converter
   assign idle = !convBusy && !convStart && !autoSequencing && !keySequencing;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_single_start: assert property (wr && cmd == CMD_SINGLE && idle |-> ##2
      (convStart && convSelect == $past(sel, 2))) else $error("single start late or wrong");
   a_start_pulse: assert property (convStart |=> !convStart)
      else $error("start longer than one cycle");
   a_single_stops_auto: assert property (wr && cmd == CMD_SINGLE |=> !autoSequencing)
      else $error("auto sequencing still on");
   a_key_mode: assert property (wr && cmd == CMD_KEY_SEQ |=>
      keySequencing == ($past(arg) == ARG_ENABLE)) else $error("key mode wrong");
   a_auto_mode: assert property (wr && cmd == CMD_AUTO_SEQ |=>
      autoSequencing == ($past(arg) == ARG_ENABLE)) else $error("auto mode wrong");
   a_arm_sticky: assert property ((wr && cmd == CMD_KEY_ARM) || keyArmed |=> keyArmed)
      else $error("key arm lost");
   a_key_single: assert property (keyStrobe && keyCode == CONV_KEY && keyArmed && idle
      |-> ##2 convStart) else $error("armed key gave no start");
   a_config_inert: assert property (wr && cmd[2:1] == 2'b00 |=> $stable(autoSequencing)
      && $stable(keySequencing) && $stable(keyArmed)) else $error("slot or depth cmd changed a mode");
   a_read_fixed: assert property (regRead && regAddr == SETUP_ADDR |=>
      regReadData[21] == !$past(faultPin) && regReadData[20:16] == SETUP_ADDR)
      else $error("read status bits wrong");
   a_read_unmapped: assert property (regRead && regAddr != SETUP_ADDR |=> regReadData == '0)
      else $error("unmapped read not zero");
   a_result_path: assert property (convDone && convBusy && !convStart |=> resultValid
      && resultSelect == $past(convSelect) && resultData ==
      (SEL_LISTED[$past(convSelect)] ? $past(convResult) : RESULT_ZERO))
      else $error("result wrong");
endmodule : adc_seq_checker

bind adc_sequencer_control adc_seq_checker #(.SEL_W(SEL_W), .RESULT_W(RESULT_W)) u_chk (
   .clock(clock), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
   .regWriteData(regWriteData), .regReadData(regReadData), .keyStrobe(keyStrobe),
   .keyCode(keyCode), .faultPin(faultPin), .convDone(convDone), .convResult(convResult),
   .convStart(convStart), .convSelect(convSelect), .convBusy(convBusy),
   .resultData(resultData), .resultSelect(resultSelect), .resultValid(resultValid),
   .autoSequencing(autoSequencing), .keySequencing(keySequencing), .keyArmed(keyArmed));

// >>> verification/tb_top.sv
// self-checking bench for the converter sequencer control
module tb_top
   import adc_seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 1'b0;
   logic        rst_b = 1'b0;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic        keyStrobe = 1'b0;
   logic        faultPin = 1'b0;
   logic        convDone = 1'b0;
   logic [4:0]  regAddr = 5'h00;
   logic [21:0] regWriteData = 22'h000000;
   logic [15:0] keyCode = 16'h0000;
   logic [11:0] convResult = 12'h000;
   logic [21:0] regReadData;
   logic        convStart, convBusy, resultValid, autoSequencing, keySequencing, keyArmed;
   logic [4:0]  convSelect, resultSelect, s, expSel;
   logic [11:0] resultData, r;
   logic [15:0] img = 16'h0000;
   logic        rdTaken = 1'b0;
   logic [21:0] rdQ[$];
   logic [16:0] cvQ[$];
   logic [4:0]  selQ[$];
   logic [4:0]  slot[8];
   logic [4:0]  odd[6] = '{5'h07, 5'h0f, 5'h00, 5'h1f, 5'h0c, 5'h0b};
   int          n_mismatch = 0;
   int          checked = 0;
   int          nStarts = 0;

   always #12.5 clock = ~clock;

   adc_sequencer_control u_adc_sequencer_control (
      .clock(clock), .rst_b(rst_b), .regWrite(regWrite), .regRead(regRead),
      .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
      .keyStrobe(keyStrobe), .keyCode(keyCode), .faultPin(faultPin), .convDone(convDone),
      .convResult(convResult), .convStart(convStart), .convSelect(convSelect),
      .convBusy(convBusy), .resultData(resultData), .resultSelect(resultSelect),
      .resultValid(resultValid), .autoSequencing(autoSequencing),
      .keySequencing(keySequencing), .keyArmed(keyArmed));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   function automatic logic [21:0] w(logic [2:0] c, logic [2:0] a, logic [4:0] sl);
      // read-only address field written back at its default
      return {1'b0, SETUP_ADDR, 5'h00, c, a, sl};
   endfunction : w

   task automatic wr(input logic [21:0] d, input logic [4:0] a = SETUP_ADDR);
      @(negedge clock);
      regWrite = 1'b1;
      regAddr = a;
      regWriteData = d;
      // only the low sixteen bits are writable
      if (a == SETUP_ADDR) img = d[15:0];
      @(negedge clock);
      regWrite = 1'b0;
      regWriteData = 22'($urandom);
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [21:0] exp);
      @(negedge clock);
      regRead = 1'b1;
      regAddr = a;
      rdQ.push_back(exp);
      @(negedge clock);
      regRead = 1'b0;
   endtask : rd

   task automatic key(input logic [15:0] code);
      @(negedge clock);
      keyStrobe = 1'b1;
      keyCode = code;
      @(negedge clock);
      keyStrobe = 1'b0;
      keyCode = 16'($urandom);
   endtask : key

   task automatic modes(input logic a, input logic k, input logic arm);
      @(negedge clock);
      check("autoSequencing", autoSequencing, a);
      check("keySequencing", keySequencing, k);
      check("keyArmed", keyArmed, arm);
   endtask : modes

   // waits out every noted conversion; a noted conversion that never starts leaves a stray note
   task automatic drain();
      for (int i = 0; i < 60 && (selQ.size() + cvQ.size() != 0 || convBusy !== 1'b0); i++)
         @(negedge clock);
      check("pending", selQ.size() + cvQ.size(), 0);
   endtask : drain

   // converter stand-in: answers each start four cycles later with a random result
   initial forever begin
      @(negedge clock);
      if (convStart === 1'b1) begin
         nStarts++;
         expSel = (selQ.size() != 0) ? selQ.pop_front() : ~convSelect;
         check("convSelect", convSelect, expSel);
         check("convBusy", convBusy, 1'b1);
         r = 12'($urandom);
         repeat (4) @(negedge clock);
         convDone = 1'b1;
         convResult = r;
         cvQ.push_back({expSel, SEL_LISTED[expSel] ? r : RESULT_ZERO});
         @(negedge clock);
         convDone = 1'b0;
         convResult = 12'($urandom);
      end
   end

   always @(posedge clock) rdTaken <= regRead;

   always @(negedge clock) begin
      if (rdTaken) begin
         check("regReadData", regReadData, rdQ.size() ? rdQ.pop_front() : ~regReadData);
      end
      if (resultValid === 1'b1) begin
         check("result", {resultSelect, resultData},
               cvQ.size() ? cvQ.pop_front() : ~{resultSelect, resultData});
         check("convBusy", convBusy, 1'b0);
      end
   end

   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      finish_test();
   end

   initial begin
      void'($urandom(85137));
      repeat (5) @(posedge clock);
      @(negedge clock);
      rst_b = 1'b1;
      for (int f = 0; f < 2; f++) begin
         faultPin = f[0];
         rd(SETUP_ADDR, {~faultPin, SETUP_ADDR, img});
      end
      rd(5'h12, 22'h000000);
      wr(w(CMD_KEY_SEQ, 3'h1, 5'h03), 5'h10);
      for (int c = 6; c < 8; c++) begin
         // legal codes only; spare bits set, modes switched off
         wr(22'h00f800 | w(3'(c - 4), 3'h2, 5'(c)));
         modes(1'b0, 1'b0, 1'b0);
         rd(SETUP_ADDR, {~faultPin, SETUP_ADDR, img});
      end
      key(CONV_KEY);
      drain();
      for (int i = 0; i < 8; i++) begin
         s = (i < 6) ? odd[i] : 5'($urandom);
         selQ.push_back(s);
         wr(w(CMD_SINGLE, 3'($urandom), s));
         drain();
      end
      for (int i = 0; i < 8; i++) begin
         slot[i] = 5'($urandom);
         wr(w(CMD_SLOT, 3'(i), slot[i]));
      end
      wr(w(CMD_DEPTH, 3'h2, 5'h01));
      wr(w(CMD_KEY_SEQ, 3'h1, 5'h02));
      modes(1'b0, 1'b1, 1'b0);
      for (int i = 0; i < 4; i++) begin
         selQ.push_back(slot[i % 3]);
         key(CONV_KEY);
         drain();
      end
      key(16'h1add);
      drain();
      wr(w(CMD_KEY_SEQ, 3'h3, 5'h02));
      modes(1'b0, 1'b0, 1'b0);
      // longest sequence, one wrap past the last slot
      wr(w(CMD_DEPTH, 3'h7, 5'h04));
      for (int i = 0; i < 9; i++) selQ.push_back(slot[i % 8]);
      nStarts = 0;
      wr(w(CMD_AUTO_SEQ, 3'h1, 5'h04));
      for (int i = 0; i < 200 && nStarts < 9; i++) @(negedge clock);
      wr(w(CMD_AUTO_SEQ, 3'h5, 5'h04));
      modes(1'b0, 1'b0, 1'b0);
      drain();
      s = 5'($urandom);
      wr(w(CMD_KEY_ARM, 3'($urandom), s));
      modes(1'b0, 1'b0, 1'b1);
      selQ.push_back(s);
      key(CONV_KEY);
      drain();
      wr(w(CMD_DEPTH, 3'h0, 5'h0a));
      modes(1'b0, 1'b0, 1'b1);
      selQ.push_back(5'h0a);
      key(CONV_KEY);
      drain();
      rst_b = 1'b0;
      img = 16'h0000;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      modes(1'b0, 1'b0, 1'b0);
      rd(SETUP_ADDR, {~faultPin, SETUP_ADDR, img});
      repeat (3) @(negedge clock);
      finish_test();
   end
endmodule : tb_top
